// file: dv/rvd_host_model.sv
// Behavioural serial-bus host that drives the clock and open-drain data lines of the register block.
`timescale 1ns/1ns
module rvd_host_model
    import rvd_pkg::*;
(
    input  wire logic clk,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda
);
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end

    // Each level is held for two clocks, so the target never sees a line change and a clock edge together.
    task automatic drive(input logic c, input logic d);
        @(posedge clk);
        scl <= c;
        sda <= d;
        @(posedge clk);
    endtask

    // Data only moves while the clock is low; a released line reads back through the wired AND.
    task automatic bit_io(input logic b, output logic got);
        drive(1'b0, b);
        drive(1'b1, b);
        got = sda_line;
        drive(1'b0, b);
    endtask

    // Also serves as a repeated start, since it first lowers the clock with data released.
    task automatic start_cond();
        drive(1'b0, 1'b1);
        drive(1'b1, 1'b1);
        drive(1'b1, 1'b0);
        drive(1'b0, 1'b0);
    endtask

    task automatic stop_cond();
        drive(1'b0, 1'b0);
        drive(1'b1, 1'b0);
        drive(1'b1, 1'b1);
    endtask

    task automatic byte_io(input logic [7:0] tx, input logic mack, output logic [7:0] rx, output logic ack);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], g);
            rx[i] = g;
        end
        bit_io(mack, g);
        ack = ~g;
    endtask

    task automatic write_reg(input logic [6:0] addr, input logic [7:0] ptr, input logic [7:0] data,
                             output logic ack);
        logic [7:0] r;
        logic       a0;
        logic       a1;
        logic       a2;
        start_cond();
        byte_io({addr, 1'b0}, 1'b1, r, a0);
        byte_io(ptr, 1'b1, r, a1);
        byte_io(data, 1'b1, r, a2);
        stop_cond();
        ack = a0 & a1 & a2;
    endtask

    // The single read byte is refused by the host, which ends the read.
    task automatic read_reg(input logic [7:0] ptr, output logic [7:0] data);
        logic [7:0] r;
        logic       a;
        start_cond();
        byte_io({DEV_ADDR, 1'b0}, 1'b1, r, a);
        byte_io(ptr, 1'b1, r, a);
        start_cond();
        byte_io({DEV_ADDR, 1'b1}, 1'b1, r, a);
        byte_io(8'hff, 1'b1, data, a);
        stop_cond();
    endtask

    // The first byte is acknowledged, so the target has to fetch the next offset by itself.
    task automatic read_two(input logic [7:0] ptr, output logic [7:0] d0, output logic [7:0] d1);
        logic [7:0] r;
        logic       a;
        start_cond();
        byte_io({DEV_ADDR, 1'b0}, 1'b1, r, a);
        byte_io(ptr, 1'b1, r, a);
        start_cond();
        byte_io({DEV_ADDR, 1'b1}, 1'b1, r, a);
        byte_io(8'hff, 1'b0, d0, a);
        byte_io(8'hff, 1'b1, d1, a);
        stop_cond();
    endtask
endmodule

// file: dv/rvd_regs_tb.sv
// Self-checking testbench for the regulator code and duty floor register block.
`timescale 1ns/1ns
module rvd_regs_tb
    import rvd_pkg::*;
;
    logic                           clk;
    logic                           reset;
    logic                           undervoltage_lockout_active;
    logic                           setting_lock;
    rvd_fuse_t                      fuse;
    rvd_fuse_t                      fz;
    logic [FLOOR_W-1:0]             duty;
    logic [FLOOR_W-1:0]             d;
    logic                           scl;
    logic                           sda_m;
    logic                           sda_line;
    logic                           sda_oe;
    logic                           sda_out;
    logic [NUM_REG-1:0][CODE_W-1:0] code;
    logic [NUM_REG-1:0][MV_W-1:0]   mv;
    logic [FLOOR_W-1:0]             floor_v;
    logic [FLOOR_W-1:0]             duty_eff;
    logic [7:0]                     rd;
    logic [7:0]                     rd2;
    logic                           ack;
    logic [5:0]                     cur;
    int                             nc;
    int                             fails;
    int                             checks_done;
    logic [7:0]                     rst_tbl [4] = '{8'h24, 8'h10, 8'hff, 8'h00};

    assign sda_line = sda_m & ~sda_oe;

    rvd_host_model host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda(sda_m));

    rvd_regs uut (
        .clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .undervoltage_lockout_active(undervoltage_lockout_active), .setting_lock(setting_lock), .fuse_in(fuse), .dimming_duty_value(duty),
        .regulator_code(code), .regulator_mv(mv), .duty_floor_value(floor_v), .dimming_duty_eff(duty_eff)
    );

    initial clk = 1'b0;
    always #5 clk = ~clk;

    function automatic logic [11:0] exp_mv(input int k);
        if (k == 25) return 12'(1405);
        if (k < 32) return 12'(800 + 25 * k);
        if (k < 61) return 12'(1600 + 50 * (k - 32));
        return 12'(3100 + 100 * (k - 61));
    endfunction

    function automatic logic [9:0] exp_eff(input logic [9:0] dv, input logic [9:0] fv);
        return (dv < fv) ? fv : dv;
    endfunction

    task automatic chk_bus(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_port(input logic [11:0] got, input logic [11:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Fuse contents are taken while lockout is active and must stand once it releases.
    task automatic reload(input rvd_fuse_t f);
        @(posedge clk);
        fuse <= f;
        undervoltage_lockout_active <= 1'b1;
        repeat (2) @(posedge clk);
        undervoltage_lockout_active <= 1'b0;
        settle(2);
    endtask

    task automatic close_out();
        $display("Counts: checks_done=%0d fails=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        #200000;
        fails++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        close_out();
    end

    initial begin
        void'($urandom(32'h2dcfed91));
        reset = 1'b1;
        undervoltage_lockout_active = 1'b1;
        setting_lock = 1'b0;
        duty = '0;
        fuse = '{code_b: 6'h10, code_a: 6'h24, floor: 10'h0ff};
        settle(12);
        chk_port(12'(code[0]), 12'h024, "reset code a");
        chk_port(12'(code[1]), 12'h010, "reset code b");
        chk_port(12'(floor_v), 12'h0ff, "reset floor");
        @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        undervoltage_lockout_active <= 1'b0;
        settle(4);
        chk_bus({7'h00, sda_out}, 8'h00, "data pin level");
        for (int i = 0; i < 4; i++) begin
            host.read_reg(OFF_REG_A + 8'(i), rd);
            chk_bus(rd, rst_tbl[i], "reset readback");
        end
        // A large downward step with the spare bits set.
        host.write_reg(DEV_ADDR, OFF_REG_A, 8'hc3, ack);
        chk_bus({7'h00, ack}, 8'h01, "write ack");
        settle(2);
        chk_port(12'(code[0]), 12'h003, "downward step");
        chk_port(mv[0], exp_mv(3), "downward mv");
        chk_port(12'(code[1]), 12'h010, "other code kept");
        host.read_reg(OFF_REG_A, rd);
        chk_bus(rd, 8'h03, "spare bits read zero");
        host.write_reg(DEV_ADDR, OFF_REG_A, 8'h04, ack);
        settle(2);
        chk_port(12'(code[0]), 12'h004, "small upward step");
        @(posedge clk);
        setting_lock <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            host.write_reg(DEV_ADDR, OFF_REG_A + 8'(i), 8'h01, ack);
        end
        settle(2);
        chk_port(12'(code[0]), 12'h004, "locked code a");
        chk_port(12'(code[1]), 12'h010, "locked code b");
        @(posedge clk);
        setting_lock <= 1'b0;
        host.write_reg(DEV_ADDR, OFF_FLOOR_LOW, 8'h12, ack);
        host.write_reg(DEV_ADDR, OFF_FLOOR_HI, 8'h03, ack);
        host.read_reg(OFF_FLOOR_LOW, rd);
        chk_bus(rd, 8'hff, "floor low after write");
        host.read_reg(OFF_FLOOR_HI, rd);
        chk_bus(rd, 8'h00, "floor high after write");
        chk_port(12'(floor_v), 12'h0ff, "floor port after write");
        host.read_reg(8'h0a, rd);
        chk_bus(rd, 8'h00, "unmapped read");
        host.write_reg(DEV_ADDR ^ 7'h01, OFF_REG_B, 8'h00, ack);
        chk_bus({7'h00, ack}, 8'h00, "foreign address ack");
        chk_port(12'(code[1]), 12'h010, "foreign address write");
        // A two-byte read walks from regulator A's offset to regulator B's.
        host.read_two(OFF_REG_A, rd, rd2);
        chk_bus(rd, 8'h04, "burst byte a");
        chk_bus(rd2, 8'h10, "burst byte b");
        cur = 6'h10;
        for (int i = 0; i < 8; i++) begin
            nc = (i == 0) ? 0 : int'($urandom_range(0, 63));
            if (100 * int'(exp_mv(nc)) > 108 * int'(exp_mv(cur))) nc = cur + 1;
            host.write_reg(DEV_ADDR, OFF_REG_B, 8'(nc), ack);
            settle(2);
            chk_port(12'(code[1]), 12'(nc), "random code b");
            chk_port(mv[1], exp_mv(nc), "random mv b");
            host.read_reg(OFF_REG_B, rd);
            chk_bus(rd, 8'(nc), "random readback b");
            cur = 6'(nc);
        end
        for (int k = 0; k < 64; k++) begin
            reload('{code_b: 6'(63 - k), code_a: 6'(k), floor: 10'($urandom)});
            chk_port(12'(code[0]), 12'(k), "fuse code a");
            chk_port(mv[0], exp_mv(k), "decode a");
            chk_port(mv[1], exp_mv(63 - k), "decode b");
            chk_port(12'(floor_v), 12'(fuse.floor), "fuse floor");
        end
        for (int i = 0; i < 24; i++) begin
            fz = '{code_b: 6'h10, code_a: 6'h24, floor: 10'($urandom)};
            d = (i == 0) ? fz.floor : (i == 1) ? fz.floor - 10'h001 : 10'($urandom);
            @(posedge clk);
            duty <= d;
            reload(fz);
            chk_port(12'(duty_eff), 12'(exp_eff(d, fz.floor)), "effective duty");
        end
        host.read_reg(OFF_FLOOR_LOW, rd);
        chk_bus(rd, fz.floor[7:0], "floor low bits");
        host.read_reg(OFF_FLOOR_HI, rd);
        chk_bus(rd, {6'h00, fz.floor[9:8]}, "floor high bits");
        close_out();
    end
endmodule

// file: hw/rvd_duty_floor.sv
// Clamps the requested dimming duty value to the factory duty floor.
`timescale 1ns/1ns
module rvd_duty_floor
    import rvd_pkg::*;
(
    input  wire logic [FLOOR_W-1:0] duty,
    input  wire logic [FLOOR_W-1:0] floor,
    output logic      [FLOOR_W-1:0] duty_eff
);

    // The stored value is untouched; only the value that drives the sink is raised.
    always_comb begin
        duty_eff = (duty < floor) ? floor : duty;
    end

endmodule

// file: hw/rvd_regs.sv
// Serial-bus target holding the regulator voltage codes and the read-only duty floor.
`timescale 1ns/1ns
// Overview of operation
// - Regulator A's register keeps a writable 6-bit code in bits 5:0 resetting to 100100, with bits 7:6 reading 00.
// - Regulator B's register keeps a writable 6-bit code in bits 5:0 resetting to 010000, with bits 7:6 reading 00.
// - All register defaults come from fuse memory and are reloaded on every clock while the undervoltage lockout is active.
// - While the setting lock is 1, writes to both voltage codes are ignored.
// - A downward voltage change of any size is accepted in one write without any internal reset.
// - Codes 0-31 give 0.800 V plus 25 mV per step (code 25 gives 1.405), 32-60 give 1.600 V plus 50 mV, 61-63 give 3.1, 3.2, 3.3 V.
// - The floor low register returns bits 7:0 of the 10-bit duty floor, resetting to 11111111.
// - The duty floor registers are read-only and host writes leave them unchanged.
// - The floor high register returns floor bits 9:8 in bits 1:0, the code running from 0% to 99.9% duty.
// - A duty value below the floor is kept as written but the dimming signal runs at the floor.
module rvd_regs
    import rvd_pkg::*;
(
    input  wire logic                            clk,
    input  wire logic                            reset,
    input  wire logic                            scl_in,
    input  wire logic                            sda_in,
    output logic                                 sda_out,
    output logic                                 sda_oe,
    input  wire logic                            undervoltage_lockout_active,
    input  wire logic                            setting_lock,
    input  wire rvd_fuse_t                       fuse_in,
    input  wire logic [FLOOR_W-1:0]              dimming_duty_value,
    output logic      [NUM_REG-1:0][CODE_W-1:0]  regulator_code,
    output logic      [NUM_REG-1:0][MV_W-1:0]    regulator_mv,
    output logic      [FLOOR_W-1:0]              duty_floor_value,
    output logic      [FLOOR_W-1:0]              dimming_duty_eff
);

    rvd_state_t                st_reg;
    rvd_state_t                st_next;
    rvd_phase_t                phase_reg;
    rvd_phase_t                phase_next;
    logic [2:0]                bit_reg;
    logic [2:0]                bit_next;
    logic [7:0]                shift_reg;
    logic [7:0]                shift_next;
    logic [7:0]                ptr_reg;
    logic [7:0]                ptr_next;
    logic                      rw_reg;
    logic                      rw_next;
    logic                      sda_oe_reg;
    logic                      sda_oe_next;
    logic                      scl_q_reg;
    logic                      sda_q_reg;
    logic                      wr_en;
    logic [7:0]                wr_addr;
    logic [7:0]                wr_data;
    logic [7:0]                rd_byte;
    logic [7:0]                rx_byte;
    logic                      scl_rise;
    logic                      scl_fall;
    logic                      bus_start;
    logic                      bus_stop;

    logic [NUM_REG-1:0][CODE_W-1:0] code_reg;
    logic [NUM_REG-1:0][CODE_W-1:0] code_next;
    logic [FLOOR_W-1:0]             floor_reg;
    logic [FLOOR_W-1:0]             floor_next;
    logic [NUM_REG-1:0][MV_W-1:0]   mv_w;
    logic [NUM_REG-1:0][MV_W-1:0]   mv_reg;
    logic [NUM_REG-1:0][MV_W-1:0]   mv_next;
    logic [FLOOR_W-1:0]             eff_w;
    logic [FLOOR_W-1:0]             eff_reg;
    logic [FLOOR_W-1:0]             eff_next;

    // Bus pins are taken as synchronous; one earlier sample is enough to see edges.
    assign scl_rise  = scl_in & ~scl_q_reg;
    assign scl_fall  = ~scl_in & scl_q_reg;
    assign bus_start = scl_in & scl_q_reg & sda_q_reg & ~sda_in;
    assign bus_stop  = scl_in & scl_q_reg & ~sda_q_reg & sda_in;
    assign rx_byte   = {shift_reg[6:0], sda_in};

    // Read mux; unmapped offsets return zero.
    always_comb begin
        rd_byte = 8'h00;
        unique case (ptr_reg)
            OFF_REG_A:     rd_byte = {2'b00, code_reg[0]};
            OFF_REG_B:     rd_byte = {2'b00, code_reg[1]};
            OFF_FLOOR_LOW: rd_byte = floor_reg[FLOOR_LOW_W-1:0];
            OFF_FLOOR_HI:  rd_byte = {6'h00, floor_reg[FLOOR_HI_MSB:FLOOR_HI_LSB]};
            default:       rd_byte = 8'h00;
        endcase
    end

    // Serial-bus target: address, pointer, then data bytes with auto-increment.
    always_comb begin
        st_next     = st_reg;
        phase_next  = phase_reg;
        bit_next    = bit_reg;
        shift_next  = shift_reg;
        ptr_next    = ptr_reg;
        rw_next     = rw_reg;
        sda_oe_next = sda_oe_reg;
        wr_en       = 1'b0;
        wr_addr     = ptr_reg;
        wr_data     = rx_byte;
        if (bus_start) begin
            st_next     = ST_RX;
            phase_next  = PH_ADDR;
            bit_next    = 3'h0;
            sda_oe_next = 1'b0;
        end else if (bus_stop) begin
            st_next     = ST_IDLE;
            sda_oe_next = 1'b0;
        end else begin
            unique case (st_reg)
                ST_IDLE: begin
                    sda_oe_next = 1'b0;
                end
                ST_RX: begin
                    if (scl_rise) begin
                        shift_next = rx_byte;
                        bit_next   = bit_reg + 3'h1;
                        if (bit_reg == 3'h7) begin
                            st_next = ST_ACK;
                            unique case (phase_reg)
                                PH_ADDR: begin
                                    rw_next = rx_byte[0];
                                    if (rx_byte[7:1] != DEV_ADDR) begin
                                        st_next = ST_IDLE;
                                    end
                                end
                                PH_PTR: begin
                                    ptr_next = rx_byte;
                                end
                                default: begin
                                    // Every data byte is acknowledged, even when it is ignored.
                                    wr_en    = 1'b1;
                                    ptr_next = ptr_reg + 8'h01;
                                end
                            endcase
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall && !sda_oe_reg) begin
                        sda_oe_next = 1'b1;
                    end else if (scl_fall) begin
                        sda_oe_next = 1'b0;
                        bit_next    = 3'h0;
                        st_next     = ST_RX;
                        if (phase_reg == PH_ADDR && rw_reg) begin
                            st_next     = ST_TX;
                            shift_next  = rd_byte;
                            sda_oe_next = ~rd_byte[7];
                        end else if (phase_reg == PH_ADDR) begin
                            phase_next = PH_PTR;
                        end else begin
                            phase_next = PH_DATA;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall && bit_reg == 3'h7) begin
                        sda_oe_next = 1'b0;
                        st_next     = ST_RACK;
                    end else if (scl_fall) begin
                        shift_next  = {shift_reg[6:0], 1'b0};
                        sda_oe_next = ~shift_reg[6];
                        bit_next    = bit_reg + 3'h1;
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        ptr_next = ptr_reg + 8'h01;
                        st_next  = sda_in ? ST_IDLE : ST_RLOAD;
                    end
                end
                ST_RLOAD: begin
                    if (scl_fall) begin
                        shift_next  = rd_byte;
                        sda_oe_next = ~rd_byte[7];
                        bit_next    = 3'h0;
                        st_next     = ST_TX;
                    end
                end
                default: begin
                    st_next     = ST_IDLE;
                    sda_oe_next = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_reg     <= ST_IDLE;
            phase_reg  <= PH_ADDR;
            bit_reg    <= 3'h0;
            shift_reg  <= 8'h00;
            ptr_reg    <= 8'h00;
            rw_reg     <= 1'b0;
            sda_oe_reg <= 1'b0;
            scl_q_reg  <= 1'b1;
            sda_q_reg  <= 1'b1;
        end else begin
            st_reg     <= st_next;
            phase_reg  <= phase_next;
            bit_reg    <= bit_next;
            shift_reg  <= shift_next;
            ptr_reg    <= ptr_next;
            rw_reg     <= rw_next;
            sda_oe_reg <= sda_oe_next;
            scl_q_reg  <= scl_in;
            sda_q_reg  <= sda_in;
        end
    end

    // Register contents. No step-size check is made here: downward jumps are taken whenever setting_lock and the lockout are both off, and
    // keeping upward steps small is left to the host.
    always_comb begin
        code_next  = code_reg;
        floor_next = floor_reg;
        if (undervoltage_lockout_active) begin
            code_next[0] = fuse_in.code_a;
            code_next[1] = fuse_in.code_b;
            floor_next   = fuse_in.floor;
        end else if (wr_en && !setting_lock) begin
            for (int i = 0; i < NUM_REG; i++) begin
                if (wr_addr == OFF_REG_A + 8'(i)) begin
                    code_next[i] = wr_data[CODE_MSB:0];
                end
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            code_reg[0] <= RST_CODE_A;
            code_reg[1] <= RST_CODE_B;
            floor_reg   <= RST_FLOOR;
        end else begin
            code_reg  <= code_next;
            floor_reg <= floor_next;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_REG; g++) begin : g_reg
            rvd_volt_decode u_decode (
                .code (code_reg[g]),
                .mv   (mv_w[g])
            );
        end
    endgenerate

    rvd_duty_floor u_floor (
        .duty     (dimming_duty_value),
        .floor    (floor_reg),
        .duty_eff (eff_w)
    );

    always_comb begin
        mv_next  = mv_w;
        eff_next = eff_w;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mv_reg  <= '0;
            // The sink starts at the floor straight after reset; later it follows a new floor_reg value one clock behind.
            eff_reg <= RST_FLOOR;
        end else begin
            mv_reg  <= mv_next;
            eff_reg <= eff_next;
        end
    end

    assign sda_out          = 1'b0;
    assign sda_oe           = sda_oe_reg;
    assign regulator_code   = code_reg;
    assign regulator_mv     = mv_reg;
    assign duty_floor_value = floor_reg;
    assign dimming_duty_eff = eff_reg;

    lock_hold_a: assert property (@(posedge clk) disable iff (reset)
        (setting_lock && !undervoltage_lockout_active) |=> (code_reg == $past(code_reg)))
        else $error("voltage code changed while locked");

    write_code_a: assert property (@(posedge clk) disable iff (reset)
        (wr_en && !setting_lock && !undervoltage_lockout_active && wr_addr == OFF_REG_A)
        |=> (code_reg[0] == $past(wr_data[CODE_MSB:0])) && (code_reg[1] == $past(code_reg[1])))
        else $error("regulator A write not stored");

    down_step_a: assert property (@(posedge clk) disable iff (reset)
        (wr_en && !setting_lock && !undervoltage_lockout_active && wr_addr == OFF_REG_B && wr_data[CODE_MSB:0] < code_reg[1])
        |=> (code_reg[1] == $past(wr_data[CODE_MSB:0])) ##1 (code_reg[1] == $past(code_reg[1])))
        else $error("downward step on regulator B not taken");

    fuse_load_a: assert property (@(posedge clk) disable iff (reset)
        undervoltage_lockout_active |=> (code_reg[0] == $past(fuse_in.code_a)) && (code_reg[1] == $past(fuse_in.code_b))
        && (floor_reg == $past(fuse_in.floor)))
        else $error("fuse defaults not loaded during lockout");

    floor_ro_a: assert property (@(posedge clk) disable iff (reset)
        !undervoltage_lockout_active |=> $stable(floor_reg))
        else $error("duty floor changed outside lockout");

    read_code_a: assert property (@(posedge clk) disable iff (reset)
        (st_reg == ST_RLOAD && scl_fall && ptr_reg == OFF_REG_B)
        |=> (shift_reg == {2'b00, $past(code_reg[1])}) && (sda_oe_reg == 1'b1))
        else $error("regulator B readback wrong");

    read_floor_a: assert property (@(posedge clk) disable iff (reset)
        (ptr_reg == OFF_FLOOR_HI) |-> (rd_byte[7:2] == 6'h00) && (rd_byte[1:0] == floor_reg[9:8]))
        else $error("floor high readback wrong");

    duty_clamp_a: assert property (@(posedge clk) disable iff (reset)
        ##1 (eff_reg >= $past(floor_reg)) && (($past(dimming_duty_value) < $past(floor_reg))
        || (eff_reg == $past(dimming_duty_value))))
        else $error("dimming duty below floor");

    volt_map_a: assert property (@(posedge clk) disable iff (reset)
        (code_reg[0] == CODE_SPECIAL) ##1 (code_reg[0] == CODE_SPECIAL) |-> (mv_reg[0] == MV_CODE_25))
        else $error("code 25 does not map to 1405 mV");

endmodule

// file: hw/rvd_volt_decode.sv
// Maps a 6-bit regulator voltage code onto its output voltage in millivolts.
`timescale 1ns/1ns
module rvd_volt_decode
    import rvd_pkg::*;
(
    input  wire logic [CODE_W-1:0] code,
    output logic      [MV_W-1:0]   mv
);

    always_comb begin
        if (code == CODE_SPECIAL) begin
            mv = MV_CODE_25;
        end else if (code < CODE_MID_FIRST) begin
            mv = MV_LOW_BASE + MV_W'(code) * MV_LOW_STEP;
        end else if (code < CODE_TOP_61) begin
            mv = MV_MID_BASE + MV_W'(code - CODE_MID_FIRST) * MV_MID_STEP;
        end else if (code == CODE_TOP_61) begin
            mv = MV_CODE_61;
        end else if (code == CODE_TOP_62) begin
            mv = MV_CODE_62;
        end else begin
            mv = MV_CODE_63;
        end
    end

endmodule

// file: inc/rvd_pkg.sv
// Package with the register map, reset values and voltage encoding of the regulator and dim-floor registers.
package rvd_pkg;

    localparam int CODE_W  = 6;
    localparam int FLOOR_W = 10;
    localparam int MV_W    = 12;
    localparam int NUM_REG = 2;

    // Register byte offsets.
    localparam logic [7:0] OFF_REG_A     = 8'h06;
    localparam logic [7:0] OFF_REG_B     = 8'h07;
    localparam logic [7:0] OFF_FLOOR_LOW = 8'h08;
    localparam logic [7:0] OFF_FLOOR_HI  = 8'h09;

    // Field positions.
    localparam int CODE_MSB     = 5;
    localparam int FLOOR_LOW_W  = 8;
    localparam int FLOOR_HI_MSB = 9;
    localparam int FLOOR_HI_LSB = 8;

    // Reset values.
    localparam logic [CODE_W-1:0]  RST_CODE_A = 6'h24;
    localparam logic [CODE_W-1:0]  RST_CODE_B = 6'h10;
    localparam logic [FLOOR_W-1:0] RST_FLOOR  = 10'h0ff;

    // Target address on the serial bus; the value is arbitrary.
    localparam logic [6:0] DEV_ADDR = 7'h2a;

    // Voltage encoding in millivolts.
    localparam logic [CODE_W-1:0] CODE_MID_FIRST = 6'h20;
    localparam logic [CODE_W-1:0] CODE_SPECIAL   = 6'h19;
    localparam logic [CODE_W-1:0] CODE_TOP_61    = 6'h3d;
    localparam logic [CODE_W-1:0] CODE_TOP_62    = 6'h3e;
    localparam logic [MV_W-1:0]   MV_LOW_BASE    = 12'h320;
    localparam logic [MV_W-1:0]   MV_LOW_STEP    = 12'h019;
    localparam logic [MV_W-1:0]   MV_CODE_25     = 12'h57d;
    localparam logic [MV_W-1:0]   MV_MID_BASE    = 12'h640;
    localparam logic [MV_W-1:0]   MV_MID_STEP    = 12'h032;
    localparam logic [MV_W-1:0]   MV_CODE_61     = 12'hc1c;
    localparam logic [MV_W-1:0]   MV_CODE_62     = 12'hc80;
    localparam logic [MV_W-1:0]   MV_CODE_63     = 12'hce4;

    typedef struct packed {
        logic [CODE_W-1:0]  code_b;
        logic [CODE_W-1:0]  code_a;
        logic [FLOOR_W-1:0] floor;
    } rvd_fuse_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_RX    = 3'b001,
        ST_ACK   = 3'b010,
        ST_TX    = 3'b011,
        ST_RACK  = 3'b100,
        ST_RLOAD = 3'b101
    } rvd_state_t;

    typedef enum logic [1:0] {
        PH_ADDR = 2'b00,
        PH_PTR  = 2'b01,
        PH_DATA = 2'b10
    } rvd_phase_t;

endpackage
